//--- erf_rx_filter.sv
// Receive address filter, priority dropper, teardown and frame classifier.
// Assumes an AHB-Lite master, an MII PHY and a DMA engine on MCLK.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Eight station addresses share upper 40 bits; lowest byte per channel.
// - Type 8100h marks a tagged frame; next two octets are the tag.
// - Tag bits 15-13 give priority; 0-3 low, 4-7 high.
// - Frames with any other type field are low priority.
// - Drop low-priority frame when channel spare count is at or below level.
// - Priority dropping works only while its enable bit is set.
// - Each consumed buffer lowers its channel spare count by one, down to zero.
// - Writes to a spare count add to it; count tops out at 65535.
// - Teardown finishes frame, flags descriptor, clears head, interrupts, loads FFFFFFFCh.
// - Teardown never changes channel enables.
// - Idle-channel teardown interrupts, no descriptor; pointer reads FFFFFFFCh.
// - Proper frame: 64 bytes to length limit, no code, alignment or CRC error.
// - Longer than limit is long: oversize if clean, jabber if errored.
// - Length limit resets to 1518 bytes.
// - Under 64 bytes is short: undersized if clean, fragment if errored.
// - Frames of 20 bytes or less always keep their CRC bytes.
// - Long frames deliver exactly limit bytes, whatever the keep-FCS bit.
// - Four accept bits admit control, short, error and unmatched-address frames.
module erf_rx_filter (
  // Clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // MII receive pins
  input wire logic MII_RXCLK,
  input wire logic MII_RXDV,
  input wire logic MII_RXER,
  input wire logic [3:0] MII_RXD,
  // Buffer consumption from the DMA engine
  input wire logic BUF_USED,
  input wire logic [erf_pkg::CH_W-1:0] BUF_CHAN,
  // Frame byte stream and end-of-frame status
  output logic OUT_VALID,
  output logic [7:0] OUT_BYTE,
  output logic OUT_END,
  output erf_pkg::erf_status_t OUT_STATUS,
  // Teardown events
  output logic TDOWN_EVT,
  output logic [erf_pkg::CH_W-1:0] TDOWN_CHAN,
  output logic TDOWN_DESC,
  output logic RX_IRQ
);
  import erf_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic a_wr;
  logic a_rd;
  logic [7:0] a_addr;
  logic [2:0] a_grp;
  logic [CH_W-1:0] a_ch;
  logic [31:0] rd_mux;
  logic [CH_W-1:0] slot_sel;
  logic [31:0] addr_upper;
  logic [7:0] addr_shared;
  logic [7:0] addr_lsb [NUM_CH];
  logic [31:0] cfg;
  logic [15:0] drop_level;
  logic [15:0] len_limit;
  logic [NUM_CH-1:0] chan_en;
  logic [15:0] spare [NUM_CH];
  logic [31:0] head_ptr [NUM_CH];
  logic [31:0] comp_ptr [NUM_CH];
  logic [NUM_CH-1:0] tdown_pend;
  logic td_go;
  logic [CH_W-1:0] td_ch;
  erf_status_t last_status;
  logic [2:0] clk_sync;
  erf_mii_t mii_s1;
  erf_mii_t mii_s2;
  logic rx_fall;
  erf_state_t state;
  logic nib_phase;
  logic [3:0] nib_lo;
  logic [7:0] new_byte;
  logic byte_stb;
  logic [15:0] len;
  logic [15:0] out_idx;
  logic [7:0] dl [4];
  logic [2:0] fill;
  logic [47:0] dest;
  logic [15:0] ltype;
  logic [2:0] prio;
  logic code_err;
  logic align_err;
  logic keep_tail;
  logic crc_ok;
  logic [NUM_CH-1:0] uc_hit;
  erf_status_t fstat;

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  assign a_grp = a_addr[7:5];
  assign a_ch = a_addr[4:2];

  // Reads take one wait state.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      a_wr <= 1'b0;
      a_rd <= 1'b0;
      a_addr <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h00000000;
    end else begin
      a_wr <= HSEL && HTRANS[1] && HREADY && HWRITE;
      if (HSEL && HTRANS[1] && HREADY) begin
        a_addr <= HADDR[7:0];
      end
      if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
        a_rd <= 1'b1;
        HREADYOUT <= 1'b0;
      end else if (a_rd) begin
        a_rd <= 1'b0;
        HREADYOUT <= 1'b1;
        HRDATA <= rd_mux;
      end
    end
  end

  // Read multiplexer; unmapped words read as zero.
  always_comb begin
    rd_mux = 32'h00000000;
    case (a_grp)
      GRP_FREE: rd_mux = {16'h0000, spare[a_ch]};
      GRP_HEAD: rd_mux = head_ptr[a_ch];
      GRP_CP: rd_mux = comp_ptr[a_ch];
      3'h0: begin
        case (a_addr)
          OFS_SLOT: rd_mux = {29'h00000000, slot_sel};
          OFS_UPPER: rd_mux = addr_upper;
          OFS_LOWER: rd_mux = {16'h0000, addr_shared, addr_lsb[slot_sel]};
          OFS_CFG: rd_mux = cfg;
          OFS_DROP: rd_mux = {16'h0000, drop_level};
          OFS_LIMIT: rd_mux = {16'h0000, len_limit};
          OFS_CHEN: rd_mux = {24'h000000, chan_en};
          default: rd_mux = 32'h00000000;
        endcase
      end
      3'h1: begin
        if (a_addr == OFS_STAT) begin
          rd_mux = {22'h000000, last_status};
        end
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Teardown has no path into chan_en, so enables survive it.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      slot_sel <= 3'h0;
      addr_upper <= 32'h00000000;
      addr_shared <= 8'h00;
      cfg <= CFG_RST;
      drop_level <= 16'h0000;
      len_limit <= LEN_LIMIT_RST;
      chan_en <= 8'h00;
    end else if (a_wr) begin
      case (a_addr)
        OFS_SLOT: slot_sel <= HWDATA[CH_W-1:0];
        OFS_UPPER: addr_upper <= HWDATA;
        OFS_LOWER: addr_shared <= HWDATA[15:8];
        OFS_CFG: cfg <= HWDATA;
        OFS_DROP: drop_level <= HWDATA[15:0];
        OFS_LIMIT: len_limit <= HWDATA[15:0];
        OFS_CHEN: chan_en <= HWDATA[NUM_CH-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Per-channel station bytes, spare counts and address match
  // ---------------------------------------------------------------
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic add_wr;
      logic [16:0] sum;
      logic [15:0] sat;
      assign add_wr = a_wr && (a_grp == GRP_FREE) && (a_ch == CH_W'(c));
      assign sum = {1'b0, spare[c]} + {1'b0, (add_wr ? HWDATA[15:0] : 16'h0000)};
      assign sat = sum[16] ? 16'hFFFF : sum[15:0];

      // Lower write lands in the selected slot.
      always_ff @(posedge MCLK) begin
        if (!NRST) begin
          addr_lsb[c] <= 8'h00;
        end else if (a_wr && a_addr == OFS_LOWER && slot_sel == CH_W'(c)) begin
          addr_lsb[c] <= HWDATA[7:0];
        end
      end

      // Refill and consumption in one cycle both apply.
      always_ff @(posedge MCLK) begin
        if (!NRST) begin
          spare[c] <= 16'h0000;
        end else if (BUF_USED && BUF_CHAN == CH_W'(c) && sat != 16'h0000) begin
          spare[c] <= sat - 16'h0001;
        end else begin
          spare[c] <= sat;
        end
      end

      assign uc_hit[c] = chan_en[c] && (dest == {addr_upper, addr_shared, addr_lsb[c]});
    end
  endgenerate

  // ---------------------------------------------------------------
  // Teardown
  // ---------------------------------------------------------------
  // Served between frames, so a frame in flight completes.
  assign td_go = (state == ST_IDLE) && (tdown_pend != 8'h00);

  // Lowest pending channel is served first.
  always_comb begin
    td_ch = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (tdown_pend[i]) begin
        td_ch = CH_W'(i);
      end
    end
  end

  // A request in the serving cycle is kept.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      tdown_pend <= 8'h00;
    end else begin
      if (td_go) begin
        tdown_pend[td_ch] <= 1'b0;
      end
      if (a_wr && a_addr == OFS_SHUT) begin
        tdown_pend[HWDATA[CH_W-1:0]] <= 1'b1;
      end
    end
  end

  // Head and completion pointers; teardown overrides a host write.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      for (int i = 0; i < NUM_CH; i++) begin
        head_ptr[i] <= 32'h00000000;
        comp_ptr[i] <= 32'h00000000;
      end
    end else begin
      if (a_wr && a_grp == GRP_HEAD) begin
        head_ptr[a_ch] <= HWDATA;
      end
      if (a_wr && a_grp == GRP_CP) begin
        comp_ptr[a_ch] <= HWDATA;
      end
      if (td_go) begin
        head_ptr[td_ch] <= 32'h00000000;
        comp_ptr[td_ch] <= SHUTDOWN_CP;
      end
    end
  end

  // Descriptor flag needs an enabled channel with a chain.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      TDOWN_EVT <= 1'b0;
      TDOWN_CHAN <= 3'h0;
      TDOWN_DESC <= 1'b0;
      RX_IRQ <= 1'b0;
    end else begin
      TDOWN_EVT <= td_go;
      TDOWN_CHAN <= td_ch;
      TDOWN_DESC <= td_go && chan_en[td_ch] && head_ptr[td_ch] != 32'h00000000;
      RX_IRQ <= td_go;
    end
  end

  // ---------------------------------------------------------------
  // MII input synchronisers
  // ---------------------------------------------------------------
  // Falling-edge sampling hits the middle of the data eye.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      clk_sync <= 3'h0;
      mii_s1 <= '0;
      mii_s2 <= '0;
    end else begin
      clk_sync <= {clk_sync[1:0], MII_RXCLK};
      mii_s1 <= {MII_RXDV, MII_RXER, MII_RXD};
      mii_s2 <= mii_s1;
    end
  end

  assign rx_fall = clk_sync[2] && !clk_sync[1];
  assign new_byte = {mii_s2.d, nib_lo};
  assign byte_stb = (state == ST_DATA) && rx_fall && mii_s2.dv && nib_phase;

  erf_crc u_crc (
    .clk(MCLK),
    .rst_n(NRST),
    .clear(state == ST_IDLE),
    .en(byte_stb),
    .data(new_byte),
    .ok(crc_ok)
  );

  // ---------------------------------------------------------------
  // Classification and acceptance
  // ---------------------------------------------------------------
  always_comb begin
    logic err;
    logic kind_ok;
    logic ctl_ok;
    logic [CH_W-1:0] m_ch;
    logic match;
    kind_ok = 1'b0;
    ctl_ok = 1'b0;
    err = !crc_ok || code_err || align_err;
    m_ch = 3'h0;
    match = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (uc_hit[i]) begin
        m_ch = CH_W'(i);
        match = 1'b1;
      end
    end
    if (!match && dest == 48'hFFFFFFFFFFFF && cfg[CFG_BC_EN]) begin
      m_ch = cfg[CFG_BC_CH +: CH_W];
      match = 1'b1;
    end
    fstat.ctl = (ltype == CTL_TYPE);
    fstat.high_prio = (ltype == TAG_TYPE) && prio[2];
    if (len > len_limit) begin
      fstat.cls = err ? CLS_JABBER : CLS_OVERSIZE;
    end else if (len < MIN_FRAME_LEN) begin
      fstat.cls = err ? CLS_FRAGMENT : CLS_UNDERSIZE;
    end else begin
      fstat.cls = err ? CLS_ERRORED : CLS_PROPER;
    end
    // Short frames need their bit; errored ones also the error bit.
    unique case (fstat.cls)
      CLS_PROPER: kind_ok = 1'b1;
      CLS_UNDERSIZE: kind_ok = cfg[CFG_SHORT_ACC];
      CLS_FRAGMENT: kind_ok = cfg[CFG_SHORT_ACC] && cfg[CFG_ERR_ACC];
      default: kind_ok = cfg[CFG_ERR_ACC];
    endcase
    ctl_ok = !fstat.ctl || cfg[CFG_CTL_ACC];
    if (!match) begin
      m_ch = cfg[CFG_PROM_CH +: CH_W];
    end
    fstat.chan = m_ch;
    fstat.drop = cfg[CFG_PRIO_DROP] && !fstat.high_prio && spare[m_ch] <= drop_level;
    fstat.accept = (match || cfg[CFG_ALL_ACC]) && kind_ok && ctl_ok && !fstat.drop;
  end

  // ---------------------------------------------------------------
  // Frame receive state machine and byte delivery
  // ---------------------------------------------------------------
  // Four bytes are held back so the CRC can be stripped.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state <= ST_IDLE;
      nib_phase <= 1'b0;
      nib_lo <= 4'h0;
      len <= 16'h0000;
      out_idx <= 16'h0000;
      fill <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        dl[i] <= 8'h00;
      end
      dest <= 48'h000000000000;
      ltype <= 16'h0000;
      prio <= 3'h0;
      code_err <= 1'b0;
      align_err <= 1'b0;
      keep_tail <= 1'b0;
      OUT_VALID <= 1'b0;
      OUT_BYTE <= 8'h00;
      OUT_END <= 1'b0;
      OUT_STATUS <= '0;
      last_status <= '0;
    end else begin
      OUT_VALID <= 1'b0;
      OUT_END <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          nib_phase <= 1'b0;
          len <= 16'h0000;
          out_idx <= 16'h0000;
          fill <= 3'h0;
          dest <= 48'h000000000000;
          ltype <= 16'h0000;
          prio <= 3'h0;
          code_err <= 1'b0;
          align_err <= 1'b0;
          if (rx_fall && mii_s2.dv) begin
            state <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (rx_fall && !mii_s2.dv) begin
            state <= ST_IDLE;
          end else if (rx_fall && mii_s2.d == 4'hD) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_fall && !mii_s2.dv) begin
            align_err <= nib_phase;
            keep_tail <= cfg[CFG_KEEP_FCS] || len <= CRC_PASS_LEN || len > len_limit;
            state <= ST_FLUSH;
          end else if (rx_fall) begin
            if (mii_s2.er) begin
              code_err <= 1'b1;
            end
            nib_phase <= !nib_phase;
            if (!nib_phase) begin
              nib_lo <= mii_s2.d;
            end
          end
          if (byte_stb) begin
            if (len != 16'hFFFF) begin
              len <= len + 16'h0001;
            end
            dl[0] <= new_byte;
            dl[1] <= dl[0];
            dl[2] <= dl[1];
            dl[3] <= dl[2];
            if (fill == 3'h4) begin
              out_idx <= out_idx + 16'h0001;
              OUT_VALID <= out_idx < len_limit;
              OUT_BYTE <= dl[3];
            end else begin
              fill <= fill + 3'h1;
            end
            if (len < 16'h0006) begin
              dest <= {dest[39:0], new_byte};
            end
            if (len == 16'h000C) begin
              ltype[15:8] <= new_byte;
            end
            if (len == 16'h000D) begin
              ltype[7:0] <= new_byte;
            end
            if (len == 16'h000E) begin
              prio <= new_byte[7:5];
            end
          end
        end
        ST_FLUSH: begin
          // Without keep_tail the held bytes are the check sequence.
          if (keep_tail && fill != 3'h0 && out_idx < len_limit) begin
            OUT_VALID <= 1'b1;
            OUT_BYTE <= dl[2'(fill - 3'h1)];
            fill <= fill - 3'h1;
            out_idx <= out_idx + 16'h0001;
          end else begin
            OUT_END <= 1'b1;
            OUT_STATUS <= fstat;
            last_status <= fstat;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- erf_pkg.sv
// Shared constants and types of the receive filter and classifier.
// Assumes one 125 MHz clock; MII pins arrive unsynchronised.
package erf_pkg;

  // ---------------------------------------------------------------
  // Sizes and frame constants
  // ---------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;
  localparam logic [15:0] CRC_PASS_LEN = 16'h0014;
  localparam logic [15:0] TAG_TYPE = 16'h8100;
  localparam logic [15:0] CTL_TYPE = 16'h8808;
  localparam logic [15:0] LEN_LIMIT_RST = 16'h05EE;
  localparam logic [31:0] SHUTDOWN_CP = 32'hFFFFFFFC;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_SLOT = 8'h00;
  localparam logic [7:0] OFS_UPPER = 8'h04;
  localparam logic [7:0] OFS_LOWER = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0C;
  localparam logic [7:0] OFS_DROP = 8'h10;
  localparam logic [7:0] OFS_LIMIT = 8'h14;
  localparam logic [7:0] OFS_SHUT = 8'h18;
  localparam logic [7:0] OFS_CHEN = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [2:0] GRP_FREE = 3'h2;
  localparam logic [2:0] GRP_HEAD = 3'h3;
  localparam logic [2:0] GRP_CP = 3'h4;

  // ---------------------------------------------------------------
  // Field positions of rx_filter_config
  // ---------------------------------------------------------------
  localparam int CFG_PROM_CH = 0;
  localparam int CFG_BC_CH = 8;
  localparam int CFG_BC_EN = 13;
  localparam int CFG_CTL_ACC = 16;
  localparam int CFG_SHORT_ACC = 17;
  localparam int CFG_ERR_ACC = 18;
  localparam int CFG_ALL_ACC = 19;
  localparam int CFG_PRIO_DROP = 29;
  localparam int CFG_KEEP_FCS = 30;
  localparam logic [31:0] CFG_RST = 32'h00000000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_PROPER = 3'h0,
    CLS_OVERSIZE = 3'h1,
    CLS_JABBER = 3'h2,
    CLS_UNDERSIZE = 3'h3,
    CLS_FRAGMENT = 3'h4,
    CLS_ERRORED = 3'h5
  } erf_class_t;

  typedef struct packed {
    logic accept;
    logic drop;
    logic high_prio;
    logic ctl;
    erf_class_t cls;
    logic [2:0] chan;
  } erf_status_t;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } erf_mii_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PRE = 4'b0010,
    ST_DATA = 4'b0100,
    ST_FLUSH = 4'b1000
  } erf_state_t;

endpackage

//--- erf_crc.sv
// Byte-wide frame check sequence checker.
// Assumes bytes arrive least significant bit first, as on the wire.
`timescale 1ns/1ps
`default_nettype none
module erf_crc (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Byte input
  input wire logic clear,
  input wire logic en,
  input wire logic [7:0] data,
  // Result
  output logic ok
);
  import erf_pkg::*;

  logic [31:0] crc;
  logic [31:0] next_crc;

  // Bitwise reflected update, eight steps per byte.
  always_comb begin
    next_crc = crc;
    for (int i = 0; i < 8; i++) begin
      if (next_crc[0] ^ data[i]) begin
        next_crc = (next_crc >> 1) ^ CRC_POLY;
      end else begin
        next_crc = next_crc >> 1;
      end
    end
  end

  // Remainder restarts with each frame.
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      crc <= CRC_INIT;
    end else if (en) begin
      crc <= next_crc;
    end
  end

  // After the check bytes the remainder is a fixed residue.
  assign ok = (crc == CRC_RESIDUE);
endmodule
`default_nettype wire

//--- erf_phy_model.sv
// Behavioural MII receive side of a PHY, sending one frame per call.
// Assumes send is called just after an MCLK edge.
`timescale 1ns/1ps
`default_nettype none
module erf_phy_model (
  // MII receive pins
  output logic rxclk,
  output logic rxdv,
  output logic rxer,
  output logic [3:0] rxd
);
  // ------
  // Nibble clocking
  // ------
  // The clock idles low outside frames.
  initial begin
    rxclk = 1'b0;
    rxdv = 1'b0;
    rxer = 1'b0;
    rxd = 4'hA;
  end

  // Data is stable at the falling edge.
  task automatic nib(input logic [3:0] n);
    rxclk = 1'b1;
    rxd = n;
    #80;
    rxclk = 1'b0;
    #80;
  endtask

  // Preamble, delimiter, bytes low nibble first, then an inverted nibble.
  task automatic send(input logic [7:0] q[$]);
    #3;
    rxdv = 1'b1;
    for (int i = 0; i < 16; i++) nib(i < 15 ? 4'h5 : 4'hD);
    foreach (q[i]) begin
      nib(q[i][3:0]);
      nib(q[i][7:4]);
    end
    rxdv = 1'b0;
    nib(~rxd);
  endtask
endmodule
`default_nettype wire

//--- erf_rx_filter_properties.sv
// Port checker for the receive filter.
// Assumes one MCLK domain; bound onto every filter instance.
`timescale 1ns/1ps
`default_nettype none
module erf_rx_filter_chk (
  // Clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Stream and events
  input wire logic OUT_VALID,
  input wire logic OUT_END,
  input wire erf_pkg::erf_status_t OUT_STATUS,
  input wire logic TDOWN_EVT,
  input wire logic TDOWN_DESC,
  input wire logic RX_IRQ
);
  import erf_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // ------
  // Helper state
  // ------
  // Limit snooped from bus writes.
  wire logic tk = HSEL && HTRANS[1] && HREADY;
  logic lim_wr;
  logic [15:0] lim;
  logic [15:0] nb;
  always_ff @(posedge MCLK) begin
    if (!NRST) lim_wr <= 1'b0;
    else lim_wr <= tk && HWRITE && HADDR[7:0] == OFS_LIMIT;
  end
  always_ff @(posedge MCLK) begin
    if (!NRST) lim <= LEN_LIMIT_RST;
    else if (lim_wr) lim <= HWDATA[15:0];
  end
  // Bytes delivered since the last end of frame.
  always_ff @(posedge MCLK) begin
    if (!NRST) nb <= 16'h0000;
    else nb <= OUT_END ? 16'h0000 : nb + 16'(OUT_VALID);
  end
  AST_OKAY: assert property (HRESP == 1'b0) else $error("response not okay");
  AST_READ_WAIT: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait wrong");
  AST_WRITE_NOWAIT: assert property (tk && HWRITE |=> HREADYOUT) else $error("write waited");
  AST_IRQ_EVT: assert property (RX_IRQ == TDOWN_EVT) else $error("irq apart");
  AST_DESC_EVT: assert property (TDOWN_DESC |-> TDOWN_EVT) else $error("lone flag");
  AST_END_PULSE: assert property (OUT_END |=> !OUT_END) else $error("end too long");
  AST_PROPER_LEN: assert property (OUT_END && OUT_STATUS.cls == CLS_PROPER
    |-> nb >= 16'h003C && nb <= lim) else $error("proper size");
  AST_SHORT_LEN: assert property (OUT_END && OUT_STATUS.cls inside {CLS_UNDERSIZE,
    CLS_FRAGMENT} |-> nb < 16'h0040) else $error("short size");
  AST_LONG_LEN: assert property (OUT_END && OUT_STATUS.cls inside {CLS_OVERSIZE,
    CLS_JABBER} |-> nb == lim) else $error("long size");
  AST_DROP: assert property (OUT_END && OUT_STATUS.drop
    |-> !OUT_STATUS.accept && !OUT_STATUS.high_prio) else $error("bad drop");
endmodule
bind erf_rx_filter erf_rx_filter_chk erf_rx_filter_chk_inst (.MCLK, .NRST, .HSEL, .HADDR,
  .HTRANS, .HWRITE, .HWDATA, .HREADY, .HREADYOUT, .HRESP, .OUT_VALID, .OUT_END,
  .OUT_STATUS, .TDOWN_EVT, .TDOWN_DESC, .RX_IRQ);
`default_nettype wire

//--- tb.sv
// Self-checking bench of the receive filter.
// Assumes the PHY model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import erf_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic buf_used = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] buf_chan = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hready, hresp, rxclk, rxdv, rxer, ovalid, oend, tevt, tdesc, irq;
  logic [2:0] tchan;
  logic [3:0] rxd;
  logic [7:0] obyte;
  logic [7:0] fr[$];
  logic [47:0] mac = 48'h021122336655;
  erf_status_t st, got_st;
  int n_errors = 0, num_checks = 0, nb = 0, got_n = -1;
  int lens[10] = '{64, 80, 81, 63, 20, 21, 90, 90, 40, 70};

  always #4 mclk = ~mclk;

  erf_rx_filter erf_rx_filter_inst (.MCLK(mclk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .MII_RXCLK(rxclk), .MII_RXDV(rxdv),
    .MII_RXER(rxer), .MII_RXD(rxd), .BUF_USED(buf_used), .BUF_CHAN(buf_chan),
    .OUT_VALID(ovalid), .OUT_BYTE(obyte), .OUT_END(oend), .OUT_STATUS(st),
    .TDOWN_EVT(tevt), .TDOWN_CHAN(tchan), .TDOWN_DESC(tdesc), .RX_IRQ(irq));
  erf_phy_model erf_phy_model_inst (.rxclk(rxclk), .rxdv(rxdv), .rxer(rxer), .rxd(rxd));

  // ------
  // Checking and bus tasks
  // ------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One bounded single transfer.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int t;
    t = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1 && ++t < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1 && ++t < 50);
    if (t >= 50) n_errors++;
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask

  task automatic used(input logic [2:0] ch);
    buf_used <= 1'b1;
    buf_chan <= ch;
    @(posedge mclk);
    buf_used <= 1'b0;
  endtask

  task automatic tdown(input logic [2:0] ch, input logic d);
    for (int t = 0; t < 20 && tevt !== 1'b1; t++) @(posedge mclk);
    chk(32'({irq, tdesc, tchan}), 32'({1'b1, d, ch}));
  endtask

  // Frame to ch0, good or spoiled CRC; pr < 0 is untagged.
  task automatic frame(input int len, input int pr, input logic bad, input logic keep,
                       input logic drop);
    logic [31:0] c;
    logic [7:0] b;
    int en;
    erf_class_t ec;
    c = CRC_INIT;
    fr = {};
    for (int i = 0; i < len - 4; i++) begin
      b = i < 6 ? mac[47 - 8 * i -: 8] : 8'($urandom);
      if (i == 12) b = pr < 0 ? 8'h08 : 8'h81;
      if (i == 13) b = 8'h00;
      if (i == 14 && pr >= 0) b = {3'(pr), b[4:0]};
      fr.push_back(b);
      for (int j = 0; j < 8; j++) c = (c >> 1) ^ ((c[0] ^ b[j]) ? CRC_POLY : 32'h0);
    end
    for (int k = 0; k < 4; k++) fr.push_back(~c[8 * k +: 8]);
    if (bad) fr[len - 1] = ~fr[len - 1];
    got_n = -1;
    erf_phy_model_inst.send(fr);
    for (int t = 0; t < 100 && got_n < 0; t++) @(posedge mclk);
    en = len > 80 ? 80 : (len <= 20 || keep) ? len : len - 4;
    ec = len > 80 ? (bad ? CLS_JABBER : CLS_OVERSIZE) : len < 64 ?
      (bad ? CLS_FRAGMENT : CLS_UNDERSIZE) : bad ? CLS_ERRORED : CLS_PROPER;
    chk(got_n, en);
    chk(32'({got_st.cls, got_st.high_prio, got_st.drop, got_st.accept, got_st.chan}),
        32'({ec, pr > 3, drop, !drop, 3'h0}));
  endtask

  // Delivered bytes match sent bytes.
  always @(posedge mclk) begin
    if (ovalid) begin
      chk({24'h0, obyte}, {24'h0, fr[nb]});
      nb++;
    end
    if (oend) begin
      got_n = nb;
      got_st = st;
      nb = 0;
    end
  end

  // ------
  // Main sequence
  // ------
  initial begin
    void'($urandom(72));
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(OFS_LIMIT, 32'h000005EE);
    rd(8'hFC, 32'h0);
    wr(OFS_SLOT, 32'h0);
    wr(OFS_UPPER, 32'h02112233);
    wr(OFS_LOWER, 32'h00004455);
    wr(OFS_SLOT, 32'h1);
    wr(OFS_LOWER, 32'h000066A7);
    wr(OFS_SLOT, 32'h0);
    rd(OFS_LOWER, 32'h00006655);
    wr(OFS_CHEN, 32'h1);
    wr(OFS_LIMIT, 32'h50);
    wr(OFS_CFG, 32'h00070000);
    for (int i = 0; i < 10; i++) frame(lens[i], int'($urandom_range(8)) - 1, i > 6, 0, 0);
    wr(OFS_CFG, 32'h40070000);
    frame(70, -1, 0, 1, 0);
    wr(OFS_DROP, 32'h2);
    wr(8'h40, 32'h2);
    wr(8'h40, 32'h1);
    rd(8'h40, 32'h3);
    used(3'h0);
    rd(8'h40, 32'h2);
    used(3'h1);
    rd(8'h44, 32'h0);
    wr(OFS_CFG, 32'h20070000);
    frame(70, -1, 0, 0, 1);
    frame(70, 5, 0, 0, 0);
    wr(8'h40, 32'h1);
    frame(70, 2, 0, 0, 0);
    used(3'h0);
    wr(OFS_CFG, 32'h00070000);
    frame(70, -1, 0, 0, 0);
    wr(8'h60, 32'h00001000);
    wr(OFS_SHUT, 32'h0);
    tdown(3'h0, 1'b1);
    rd(8'h60, 32'h0);
    rd(8'h80, SHUTDOWN_CP);
    rd(OFS_CHEN, 32'h1);
    wr(OFS_SHUT, 32'h5);
    tdown(3'h5, 1'b0);
    wr(8'h94, SHUTDOWN_CP);
    rd(8'h94, SHUTDOWN_CP);
    summarize();
  end

  // Watchdog beyond the expected run.
  initial begin
    #800000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
